// file: src/hbus_pkg.sv
// Constants and types shared by both ends of the host bus write/select port
// How it works
// - Generic mode: write strobe, rising edge latches data
// - Enable-clock mode: direction pin high reads, low writes
// - Address-strobe mode: direction pin high reads, low writes
// - Device ignores the bus while select high
// - Host drives select low from its sequencer state for the whole cycle
// - Two static straps fix the bus type
// - Read pin: low strobe or high enable clock
package hbus_pkg;
   // =========================================================
   // Widths and strap encodings
   localparam int          DATA_W         = 8;
   localparam int          ADDR_W         = 16;
   localparam logic [1:0]  STRAP_GENERIC  = 2'h0;
   localparam logic [1:0]  STRAP_ECLK     = 2'h1;
   localparam logic [1:0]  STRAP_ASTROBE  = 2'h2;
   localparam logic        PIN_IDLE       = 1'h1;
   localparam logic        DIR_READ       = 1'h1;
   localparam logic        DIR_WRITE      = 1'h0;
   // Host strobe phases, in clk cycles at 50 MHz
   localparam int          SETUP_CYC      = 2;
   localparam int          STROBE_CYC     = 4;
   localparam int          HOLD_CYC       = 2;
   localparam logic [2:0]  CNT_ZERO       = 3'h0;
   localparam logic [2:0]  CNT_ONE        = 3'h1;

   typedef enum logic [1:0] {BUS_GENERIC, BUS_ECLK, BUS_ASTROBE} bus_e;

   // Decoding used by both ends
   function automatic bus_e decode_straps(input logic [1:0] s);
      unique case (s)
         STRAP_ECLK:    decode_straps = BUS_ECLK;
         STRAP_ASTROBE: decode_straps = BUS_ASTROBE;
         default:       decode_straps = BUS_GENERIC;
      endcase
   endfunction : decode_straps
endpackage : hbus_pkg

// file: src/hbus_if.sv
// Interface joining the host and the device ends of the port
`timescale 1ns/1ns
interface hbus_if;
   import hbus_pkg::*;
   logic [1:0]        bus_type_straps;
   logic              cs_n;
   logic              wr_dir;
   logic              rd_en;
   logic              as_n;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] d_host;
   logic              d_host_oe;
   logic [DATA_W-1:0] d_dev;
   logic              d_dev_oe;

   modport host (output bus_type_straps, cs_n, wr_dir, rd_en, as_n, addr,
                 d_host, d_host_oe, input d_dev, d_dev_oe);
   modport dev  (input bus_type_straps, cs_n, wr_dir, rd_en, as_n, addr,
                 d_host, d_host_oe, output d_dev, d_dev_oe);
endinterface : hbus_if

// file: src/hbus_dev.sv
// Device end: pin sampling, mode decode, write capture and read drive
`timescale 1ns/1ns
module hbus_dev
   import hbus_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rstn,
   hbus_if.dev                    bus,
   output logic                   wr_valid,
   output logic [ADDR_W-1:0]      wr_addr,
   output logic [DATA_W-1:0]      wr_data,
   output logic                   rd_active,
   output logic [ADDR_W-1:0]      rd_addr,
   input  wire logic [DATA_W-1:0] rd_data
);
   // =========================================================
   // Pin synchronisers; pins are asynchronous to clk
   logic [2:0]        s1_reg, s2_reg, s3_reg;
   logic [1:0]        st1_reg, st2_reg;
   logic [DATA_W-1:0] d1_reg, d2_reg;
   logic [ADDR_W-1:0] a1_reg, a2_reg;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s1_reg  <= {3{PIN_IDLE}};
         s2_reg  <= {3{PIN_IDLE}};
         s3_reg  <= {3{PIN_IDLE}};
         st1_reg <= STRAP_GENERIC;
         st2_reg <= STRAP_GENERIC;
      end else begin
         s1_reg  <= {bus.cs_n, bus.wr_dir, bus.rd_en};
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         st1_reg <= bus.bus_type_straps;
         st2_reg <= st1_reg;
      end
   end
   // Data and address are held stable across the strobe, no reset needed
   always_ff @(posedge clk) begin
      d1_reg <= bus.d_host;
      d2_reg <= d1_reg;
      a1_reg <= bus.addr;
      a2_reg <= a1_reg;
   end

   // =========================================================
   // Decode
   bus_e mode;
   wire  sel     = ~s2_reg[2];
   wire  wr_now  = s2_reg[1];
   wire  wr_old  = s3_reg[1];
   wire  rd_now  = s2_reg[0];
   wire  rd_old  = s3_reg[0];
   wire  gen_wr  = (mode == BUS_GENERIC) & sel & ~wr_old & wr_now;
   // Enable clock falling edge ends a transfer with direction low
   wire  ecl_wr  = (mode == BUS_ECLK) & sel & rd_old & ~rd_now
                   & (wr_now == DIR_WRITE);
   // Address-strobe mode uses the read pin as low data strobe
   wire  ast_wr  = (mode == BUS_ASTROBE) & sel & ~rd_old & rd_now
                   & (wr_now == DIR_WRITE);
   wire  rd_gen  = (mode == BUS_GENERIC) & sel & ~rd_now;
   wire  rd_ecl  = (mode == BUS_ECLK) & sel & rd_now
                   & (wr_now == DIR_READ);
   wire  rd_ast  = (mode == BUS_ASTROBE) & sel & ~rd_now
                   & (wr_now == DIR_READ);
   wire  rd_any  = rd_gen | rd_ecl | rd_ast;
   wire  wr_any  = gen_wr | ecl_wr | ast_wr;
   assign mode   = decode_straps(st2_reg);

   // =========================================================
   // Capture and drive
   // Read drive lags the pins by the synchroniser delay; host must allow it
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wr_valid  <= 1'h0;
         wr_addr   <= '0;
         wr_data   <= '0;
         rd_active <= 1'h0;
         rd_addr   <= '0;
         bus.d_dev    <= '0;
         bus.d_dev_oe <= 1'h0;
      end else begin
         wr_valid  <= wr_any;
         rd_active <= rd_any;
         bus.d_dev_oe <= rd_any;
         if (wr_any) begin
            wr_addr <= a2_reg;
            wr_data <= d2_reg;
         end
         if (rd_any) begin
            rd_addr   <= a2_reg;
            bus.d_dev <= rd_data;
         end
      end
   end
endmodule : hbus_dev

// file: src/hbus_host.sv
// Host end: runs single read or write cycles in the strapped bus style
`timescale 1ns/1ns
module hbus_host
   import hbus_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rstn,
   hbus_if.host                   bus,
   input  wire logic [1:0]        bus_type_straps,
   input  wire logic              req,
   input  wire logic              req_write,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   output logic                   ready,
   output logic                   done,
   output logic [DATA_W-1:0]      rdata
);
   typedef enum logic [1:0] {IDLE, SETUP, STROBE, HOLD} st_e;
   st_e        st_reg, st_next;
   logic [2:0] cnt_reg;
   logic       wr_reg;
   bus_e       mode;
   assign mode = decode_straps(bus_type_straps);
   assign bus.bus_type_straps = bus_type_straps;
   assign ready = (st_reg == IDLE);
   wire   last  = (cnt_reg == CNT_ONE);
   // Select stands for the whole cycle, as an address decoder would give
   wire   sel   = (st_reg != IDLE);
   wire   strb  = (st_reg == STROBE);

   // =========================================================
   // Pin levels per bus type
   assign bus.cs_n      = ~sel;
   assign bus.as_n      = ~(sel & (mode == BUS_ASTROBE));
   // Generic: write strobe low; else direction line
   assign bus.wr_dir    = (mode == BUS_GENERIC) ? ~(strb & wr_reg)
                          : (sel ? ~wr_reg : DIR_READ);
   assign bus.rd_en     = (mode == BUS_ECLK) ? strb
                          : ~(strb & ~(wr_reg & (mode == BUS_GENERIC)));
   assign bus.d_host_oe = sel & wr_reg;

   always_comb begin
      st_next = st_reg;
      unique case (st_reg)
         IDLE:   if (req) st_next = SETUP;
         SETUP:  if (last) st_next = STROBE;
         STROBE: if (last) st_next = HOLD;
         HOLD:   if (last) st_next = IDLE;
      endcase
   end

   // =========================================================
   // Sequencer; data held through HOLD so it stays valid past the edge
   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_reg   <= IDLE;
         cnt_reg  <= CNT_ZERO;
         wr_reg   <= 1'h0;
         done     <= 1'h0;
         rdata    <= '0;
         bus.addr <= '0;
         bus.d_host <= '0;
      end else begin
         st_reg <= st_next;
         done   <= (st_reg == HOLD) & last;
         if (st_reg == IDLE && req) begin
            wr_reg     <= req_write;
            bus.addr   <= req_addr;
            bus.d_host <= req_wdata;
            cnt_reg    <= 3'(SETUP_CYC);
         end else if (st_reg != IDLE && last) begin
            cnt_reg <= (st_reg == SETUP) ? 3'(STROBE_CYC) : 3'(HOLD_CYC);
         end else if (st_reg != IDLE) begin
            cnt_reg <= cnt_reg - CNT_ONE;
         end
         if (strb && last && !wr_reg && bus.d_dev_oe) begin
            rdata <= bus.d_dev;
         end
      end
   end
endmodule : hbus_host

// file: tb/hbus_properties.sv
// Concurrent checks on the pins between the host and device ends
`timescale 1ns/1ns
module hbus_properties
   import hbus_pkg::*;
(
   input wire logic              clk,
   input wire logic              rstn,
   input wire logic [1:0]        bus_type_straps,
   input wire logic              cs_n,
   input wire logic              wr_dir,
   input wire logic              rd_en,
   input wire logic              as_n,
   input wire logic [DATA_W-1:0] d_host,
   input wire logic              d_host_oe,
   input wire logic              d_dev_oe
);
   // =========================================================
   // Pin relations
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   wire gen  = bus_type_straps inside {STRAP_GENERIC, 2'h3};
   wire eclk = bus_type_straps == STRAP_ECLK;
   wire astb = bus_type_straps == STRAP_ASTROBE;
   wire wr   = wr_dir == DIR_WRITE;
   sequence data_held; d_host_oe && $stable(d_host); endsequence
   sequence sel_window; !cs_n [*6] ##[1:4] cs_n; endsequence
   AST_WR_LATCH: assert property (gen && !cs_n && $rose(wr_dir)
      |-> data_held) else $error("write data not held at strobe");
   AST_ECLK_DIR: assert property (eclk && !cs_n && rd_en
      |-> $stable(wr_dir) && d_host_oe == wr) else $error("eclk dir");
   AST_AS_DIR: assert property (astb && !cs_n && !rd_en
      |-> !as_n && $stable(wr_dir) && d_host_oe == wr) else $error("as dir");
   AST_DEV_SEL: assert property ($rose(d_dev_oe)
      |-> !cs_n && !$past(cs_n, 2)) else $error("device drove unselected");
   AST_SEL_WINDOW: assert property ($fell(cs_n)
      |-> sel_window) else $error("select window length");
   AST_STRAP_STATIC: assert property (!$stable(bus_type_straps)
      |-> cs_n) else $error("straps moved inside a cycle");
   AST_NO_CONTEND: assert property (!(d_host_oe && d_dev_oe))
      else $error("both ends drive data");
   AST_STROBE_SEL: assert property (gen && $fell(wr_dir)
      |-> !cs_n) else $error("strobe outside select");
endmodule : hbus_properties

// file: tb/host_bus_write_select_tb_top.sv
// Bench: host and device ends joined, plus a rogue driver on a second bus
`timescale 1ns/1ns
module host_bus_write_select_tb_top;
   import hbus_pkg::*;
   logic              clk = 1'h0;
   logic              rstn = 1'h0;
   logic [1:0]        straps = 2'h0;
   logic              req = 1'h0;
   logic              req_write = 1'h0;
   logic [ADDR_W-1:0] req_addr = 16'h0000;
   logic [DATA_W-1:0] req_wdata = 8'h00;
   logic [DATA_W-1:0] rd_data = 8'h00;
   logic              ready, done, wr_valid, x_valid, x_rd;
   logic              seen_x = 1'h0;
   logic [DATA_W-1:0] rdata, wr_data;
   logic [ADDR_W-1:0] wr_addr;
   logic              rd_active;
   logic [ADDR_W-1:0] rd_addr;
   logic [24:0]       e;
   logic [24:0]       q[$];
   logic [23:0]       wq[$];
   int                mismatches = 0;
   int                checks_done = 0;
   int                seed = 76435;
   hbus_if bus();
   hbus_if bus2();
   hbus_host hbus_host_i(.clk, .rstn, .bus(bus.host), .req, .req_write,
      .bus_type_straps(straps), .req_addr, .req_wdata, .ready, .done, .rdata);
   hbus_dev hbus_dev_i(.clk, .rstn, .bus(bus.dev), .wr_valid, .wr_addr,
      .wr_data, .rd_active, .rd_addr, .rd_data);
   // Rogue end: strobes with select high must leave it silent
   hbus_dev hbus_dev_x_i(.clk, .rstn, .bus(bus2.dev), .wr_valid(x_valid),
      .wr_addr(), .wr_data(), .rd_active(x_rd), .rd_addr(), .rd_data);
   hbus_properties hbus_properties_i(.clk, .rstn, .cs_n(bus.cs_n),
      .bus_type_straps(bus.bus_type_straps), .wr_dir(bus.wr_dir),
      .rd_en(bus.rd_en), .as_n(bus.as_n), .d_host(bus.d_host),
      .d_host_oe(bus.d_host_oe), .d_dev_oe(bus.d_dev_oe));
   always #10 clk = ~clk;
   task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report
   task automatic xfer(input logic w);
      logic [ADDR_W-1:0] a;
      logic [DATA_W-1:0] d;
      int                c;
      a = ADDR_W'($random(seed));
      d = DATA_W'($random(seed));
      req <= 1'h1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      rd_data <= d;
      q.push_back({w, a, d});
      if (w) wq.push_back({a, d});
      @(posedge clk);
      for (int n = 0; n < 4 && ready !== 1'h1; n++) @(posedge clk);
      req <= 1'h0;
      c = 0;
      while (c < 20 && done !== 1'h1) begin
         @(posedge clk);
         c++;
      end
      // Done is seen here one edge after the sequencer raises it
      cmp(24'(c), 24'(SETUP_CYC + STROBE_CYC + HOLD_CYC + 1));
   endtask : xfer
   // =========================================================
   // Monitor: pops the oldest note as each result appears
   always @(posedge clk) begin
      if (rstn && (x_valid !== 1'h0 || x_rd !== 1'h0 ||
                   bus2.d_dev_oe !== 1'h0)) seen_x <= 1'h1;
      if (wr_valid === 1'h1) cmp({wr_addr, wr_data}, wq.pop_front());
      if (done === 1'h1) begin
         e = q.pop_front();
         cmp({23'h000000, rd_active}, {23'h000000, ~e[24]});
         if (!e[24]) cmp({rd_addr, rdata}, e[23:0]);
      end
   end
   initial begin
      #100000;
      mismatches++;
      $display("[ERR] %0t watchdog expired", $time);
      final_report();
   end
   initial begin
      {bus2.bus_type_straps, bus2.wr_dir, bus2.rd_en} = 4'h3;
      {bus2.cs_n, bus2.as_n, bus2.d_host_oe} = 3'h6;
      {bus2.addr, bus2.d_host} = 24'h000000;
      repeat (20) @(posedge clk);
      rstn <= 1'h1;
      for (int j = 0; j < 48; j++) begin
         @(posedge clk);
         bus2.bus_type_straps <= j[5:4];
         {bus2.wr_dir, bus2.rd_en, bus2.d_host} <= 10'($random(seed));
      end
      // Let the last strobes pass the synchronisers before judging
      repeat (5) @(posedge clk);
      cmp({23'h000000, seen_x}, 24'h000000);
      $display("Test rogue strobes done");
      for (int m = 0; m < 4; m++) begin
         straps <= m[1:0];
         repeat (2) @(posedge clk);
         for (int k = 0; k < 6; k++) xfer(k[0]);
         repeat (6) @(posedge clk);
         $display("Test bus type %0d done", m);
      end
      cmp(24'(wq.size() + q.size()), 24'h000000);
      final_report();
   end
endmodule : host_bus_write_select_tb_top
